// File: design/icsm_map.vh
`ifndef ICSM_MAP_VH
`define ICSM_MAP_VH
// ****************************************
// Clock and timing
// ****************************************
`define ICSM_CLK_MHZ     25
`define ICSM_PULLIN_US   1000
`define ICSM_FAST_PPM    16'h0FA0
`define ICSM_PPM_SCALE   48'h0000_000F_4240
`define ICSM_REF_LOS_LIM 8'h40
// ****************************************
// Register offsets
// ****************************************
`define ICSM_A_CTRL   8'h00
`define ICSM_A_LOSCFG 8'h04
`define ICSM_A_PRIO   8'h08
`define ICSM_A_WIN    8'h0C
`define ICSM_A_LIM    8'h10
`define ICSM_A_LIVE   8'h14
`define ICSM_A_STICKY 8'h18
`define ICSM_A_MASK   8'h1C
`define ICSM_A_NOM0   8'h20
`define ICSM_A_NOM1   8'h24
`define ICSM_A_NOM2   8'h28
`define ICSM_A_NOM3   8'h2C
// ****************************************
// Control and LOS config field positions
// ****************************************
`define ICSM_C_REGSEL 0
`define ICSM_C_MAN_LO 1
`define ICSM_C_AUTO   3
`define ICSM_C_REVERT 4
`define ICSM_C_ZDM    5
`define ICSM_C_HITL   6
`define ICSM_C_KEEP   7
`define ICSM_C_FREF   8
`define ICSM_C_PREN   11
`define ICSM_C_FSEN   12
`define ICSM_L_REFEN  4
// ****************************************
// Reset values
// ****************************************
`define ICSM_CTRL_RST   32'h0000_1800
`define ICSM_LOSCFG_RST 32'h0000_001F
`define ICSM_PRIO_RST   32'h0000_00E4
`define ICSM_WIN_RST    32'h0000_0103
`define ICSM_LIM_RST    32'hFFFF_FFFF
`define ICSM_MASK_RST   32'h0000_0000
`define ICSM_NOM_RST    24'h00_1000
`endif

// File: design/icsm_top.v
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "icsm_map.vh"
module icsm_top #(
  parameter        GATE_LOG      = 12,
  parameter        FAST_LOG      = 8,
  parameter [23:0] PULLIN_CYCLES = `ICSM_PULLIN_US * `ICSM_CLK_MHZ
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Clock pins and select pins
  input  wire        clock_input_zero_i,
  input  wire        clock_input_one_i,
  input  wire        clock_input_two_i,
  input  wire        clock_input_three_i,
  input  wire        reference_pin_i,
  input  wire [1:0]  sel_pin_i,
  // Loop control and status
  output wire [1:0]  active_sel_o,
  output wire        ref_valid_o,
  output wire        holdover_o,
  output wire        freerun_o,
  output wire        lock_loss_flag_o,
  output reg         phase_absorb_o,
  output reg         outputs_enable_o,
  output reg         status_interrupt_pin_o
);

  localparam [3:0] ST_FREE = 4'b0001;
  localparam [3:0] ST_ACQ  = 4'b0010;
  localparam [3:0] ST_LOCK = 4'b0100;
  localparam [3:0] ST_HOLD = 4'b1000;
  localparam       FSH     = GATE_LOG - FAST_LOG;

  integer i;

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] bmask;
    input [3:0] s;
    begin
      bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  function over_ppm;
    input [23:0] cnt;
    input [23:0] expc;
    input [15:0] ppm;
    reg   [23:0] d;
    reg   [47:0] l;
    reg   [47:0] r;
    begin
      d = (cnt > expc) ? cnt - expc : expc - cnt;
      l = {24'h00_0000, d} * `ICSM_PPM_SCALE;
      r = {32'h0000_0000, ppm} * {24'h00_0000, expc};
      over_ppm = l > r;
    end
  endfunction

  function [2:0] pick;
    input [3:0] v;
    input [7:0] pr;
    integer     p;
    integer     k;
    reg   [2:0] r;
    begin
      r = 3'b000;
      for (p = 3; p >= 0; p = p - 1) begin
        for (k = 3; k >= 0; k = k - 1) begin
          if (v[k] && pr[2*k +: 2] == p) begin
            r = {1'b1, k[1:0]};
          end
        end
      end
      pick = r;
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [3:0] pins = {clock_input_three_i, clock_input_two_i,
                     clock_input_one_i, clock_input_zero_i};
  reg  [3:0] in_s1_reg;
  reg  [3:0] in_s2_reg;
  reg  [3:0] in_s3_reg;
  reg  [2:0] ref_s_reg;
  reg  [1:0] sel_s1_reg;
  reg  [1:0] sel_s2_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      in_s1_reg  <= 4'h0;
      in_s2_reg  <= 4'h0;
      in_s3_reg  <= 4'h0;
      ref_s_reg  <= 3'h0;
      sel_s1_reg <= 2'h0;
      sel_s2_reg <= 2'h0;
    end else begin
      in_s1_reg  <= pins;
      in_s2_reg  <= in_s1_reg;
      in_s3_reg  <= in_s2_reg;
      ref_s_reg  <= {ref_s_reg[1:0], reference_pin_i};
      sel_s1_reg <= sel_pin_i;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  wire [3:0] in_rise  = in_s2_reg & ~in_s3_reg;
  wire       ref_rise = ref_s_reg[1] & ~ref_s_reg[2];

  // ****************************************
  // Registers
  // ****************************************
  reg  [31:0] ctrl_reg;
  reg  [31:0] loscfg_reg;
  reg  [31:0] prio_reg;
  reg  [31:0] win_reg;
  reg  [31:0] lim_reg;
  reg  [31:0] mask_reg;
  reg  [31:0] sticky_reg;
  reg  [23:0] nom_reg [0:3];
  reg  [31:0] rdata;
  wire [31:0] bm  = bmask(wb_sel_i);
  wire        acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr  = acc & wb_we_i;

  // ****************************************
  // Loss of signal monitors
  // ****************************************
  reg  [7:0] per_cnt_reg [0:3];
  reg  [3:0] los_reg;
  reg  [7:0] ref_cnt_reg;
  reg        ref_los_reg;
  wire [3:0] los_en = loscfg_reg[3:0];

  // Limit must cover the longest gap of a valid gapped source
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 4; i = i + 1) begin
        per_cnt_reg[i] <= 8'h00;
      end
      los_reg     <= 4'h0;
      ref_cnt_reg <= 8'h00;
      ref_los_reg <= 1'b0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (in_rise[i]) begin
          per_cnt_reg[i] <= 8'h00;
          if (per_cnt_reg[i] < lim_reg[8*i +: 8]) begin
            los_reg[i] <= 1'b0;
          end
        end else begin
          if (per_cnt_reg[i] != 8'hFF) begin
            per_cnt_reg[i] <= per_cnt_reg[i] + 8'h01;
          end
          if (per_cnt_reg[i] >= lim_reg[8*i +: 8]) begin
            los_reg[i] <= 1'b1;
          end
        end
        if (!los_en[i]) begin
          los_reg[i] <= 1'b0;
        end
      end
      if (ref_rise) begin
        ref_cnt_reg <= 8'h00;
        if (ref_cnt_reg < `ICSM_REF_LOS_LIM) begin
          ref_los_reg <= 1'b0;
        end
      end else begin
        if (ref_cnt_reg != 8'hFF) begin
          ref_cnt_reg <= ref_cnt_reg + 8'h01;
        end
        if (ref_cnt_reg >= `ICSM_REF_LOS_LIM) begin
          ref_los_reg <= 1'b1;
        end
      end
      if (!loscfg_reg[`ICSM_L_REFEN]) begin
        ref_los_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Frequency monitors
  // ****************************************
  wire [2:0]          fsel = ctrl_reg[`ICSM_C_FREF +: 3];
  wire [1:0]          fidx = fsel[1:0] - 2'd1;
  wire                gate_edge = (fsel == 3'd0) ? ref_rise :
                                  (fsel < 3'd5) ? in_rise[fidx] : 1'b0;
  reg  [GATE_LOG-1:0] gate_reg;
  wire                prec_end = gate_edge & (&gate_reg);
  wire                fast_end = gate_edge & (&gate_reg[FAST_LOG-1:0]);
  reg  [23:0]         pcnt_reg [0:3];
  reg  [23:0]         fcnt_reg [0:3];
  reg  [3:0]          prec_reg;
  reg  [3:0]          fast_reg;
  wire [7:0]          wn  = win_reg[7:0];
  wire [7:0]          hy  = win_reg[15:8];
  wire [7:0]          wc  = (wn > hy) ? wn - hy : 8'h00;
  wire [15:0]         set_ppm = {7'h00, wn, 1'b0};
  wire [15:0]         clr_ppm = {7'h00, wc, 1'b0};
  wire [23:0]         one = 24'h00_0001;

  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_reg <= {GATE_LOG{1'b0}};
      prec_reg <= 4'h0;
      fast_reg <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        pcnt_reg[i] <= 24'h00_0000;
        fcnt_reg[i] <= 24'h00_0000;
      end
    end else begin
      if (gate_edge) begin
        gate_reg <= gate_reg + one[GATE_LOG-1:0];
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (prec_end) begin
          pcnt_reg[i] <= in_rise[i] ? one : 24'h00_0000;
          if (!prec_reg[i] && over_ppm(pcnt_reg[i], nom_reg[i], set_ppm)) begin
            prec_reg[i] <= 1'b1;
          end else if (prec_reg[i] &&
                       !over_ppm(pcnt_reg[i], nom_reg[i], clr_ppm)) begin
            prec_reg[i] <= 1'b0;
          end
        end else if (in_rise[i]) begin
          pcnt_reg[i] <= pcnt_reg[i] + one;
        end
        if (fast_end) begin
          fcnt_reg[i] <= in_rise[i] ? one : 24'h00_0000;
          fast_reg[i] <= over_ppm(fcnt_reg[i], nom_reg[i] >> FSH,
                                  `ICSM_FAST_PPM);
        end else if (in_rise[i]) begin
          fcnt_reg[i] <= fcnt_reg[i] + one;
        end
      end
    end
  end

  wire [3:0] ferr = (prec_reg & {4{ctrl_reg[`ICSM_C_PREN]}}) |
                    (fast_reg & {4{ctrl_reg[`ICSM_C_FSEN]}});

  // ****************************************
  // Input selection
  // ****************************************
  reg  [3:0]  state_reg;
  reg  [1:0]  cur_reg;
  reg  [23:0] pull_reg;
  reg         locked_once_reg;
  wire        zdm   = ctrl_reg[`ICSM_C_ZDM];
  wire [3:0]  valid = ~los_reg & ~ferr & {~zdm, 3'b111};
  wire [2:0]  best  = pick(valid, prio_reg[7:0]);
  wire [1:0]  man   = ctrl_reg[`ICSM_C_REGSEL] ?
                      ctrl_reg[`ICSM_C_MAN_LO +: 2] : sel_s2_reg;
  wire        man_ok = ~(zdm & (man == 2'd3)) & ~los_reg[man];
  wire        keep  = ~ctrl_reg[`ICSM_C_REVERT] &
                      (state_reg[1] | state_reg[2]) & valid[cur_reg];
  reg  [1:0]  tgt;
  reg         tgt_ok;

  always @* begin
    tgt    = cur_reg;
    tgt_ok = 1'b0;
    if (!ctrl_reg[`ICSM_C_AUTO]) begin
      tgt    = man;
      tgt_ok = man_ok;
    end else if (keep) begin
      tgt_ok = 1'b1;
    end else begin
      tgt    = best[1:0];
      tgt_ok = best[2];
    end
  end

  wire lost_to = locked_once_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg       <= ST_FREE;
      cur_reg         <= 2'd0;
      pull_reg        <= 24'h00_0000;
      locked_once_reg <= 1'b0;
      phase_absorb_o  <= 1'b0;
    end else begin
      phase_absorb_o <= 1'b0;
      case (state_reg)
        ST_FREE, ST_HOLD: begin
          if (tgt_ok) begin
            cur_reg   <= tgt;
            pull_reg  <= PULLIN_CYCLES;
            state_reg <= ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (!tgt_ok) begin
            state_reg <= lost_to ? ST_HOLD : ST_FREE;
          end else if (tgt != cur_reg) begin
            cur_reg        <= tgt;
            pull_reg       <= PULLIN_CYCLES;
            phase_absorb_o <= ctrl_reg[`ICSM_C_HITL];
          end else if (pull_reg == 24'h00_0000) begin
            state_reg       <= ST_LOCK;
            locked_once_reg <= 1'b1;
          end else begin
            pull_reg <= pull_reg - 24'h00_0001;
          end
        end
        ST_LOCK: begin
          if (!tgt_ok) begin
            state_reg <= ST_HOLD;
          end else if (tgt != cur_reg) begin
            cur_reg        <= tgt;
            pull_reg       <= PULLIN_CYCLES;
            state_reg      <= ST_ACQ;
            phase_absorb_o <= ctrl_reg[`ICSM_C_HITL];
          end
        end
        default: begin
          state_reg <= ST_FREE;
        end
      endcase
    end
  end

  assign active_sel_o     = cur_reg;
  assign ref_valid_o      = state_reg[1] | state_reg[2];
  assign holdover_o       = state_reg[3];
  assign freerun_o        = state_reg[0];
  assign lock_loss_flag_o = ~state_reg[2];

  // ****************************************
  // Status, sticky bits and interrupt
  // ****************************************
  reg         hold_d_reg;
  wire        lock_loss_flag  = ~state_reg[2];
  wire [31:0] live = {13'h0000, state_reg[0], cur_reg, 2'b00, state_reg[3],
                      lock_loss_flag, ferr, 3'b000, ref_los_reg, los_reg};
  wire [31:0] sset = {18'h0_0000, state_reg[3] ^ hold_d_reg,
                      lock_loss_flag, ferr, 3'b000, ref_los_reg, los_reg};
  wire [31:0] sclr = (wr && wb_adr_i == `ICSM_A_STICKY) ? (wb_dat_i & bm) :
                     32'h0000_0000;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sticky_reg             <= 32'h0000_0000;
      hold_d_reg             <= 1'b0;
      status_interrupt_pin_o <= 1'b0;
      outputs_enable_o       <= 1'b1;
    end else begin
      hold_d_reg             <= state_reg[3];
      sticky_reg             <= (sticky_reg & ~sclr) | sset;
      status_interrupt_pin_o <= |(sticky_reg & mask_reg);
      outputs_enable_o       <= ~(ref_los_reg & ~ctrl_reg[`ICSM_C_KEEP]);
    end
  end

  // ****************************************
  // Wishbone register access
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= `ICSM_CTRL_RST;
      loscfg_reg <= `ICSM_LOSCFG_RST;
      prio_reg   <= `ICSM_PRIO_RST;
      win_reg    <= `ICSM_WIN_RST;
      lim_reg    <= `ICSM_LIM_RST;
      mask_reg   <= `ICSM_MASK_RST;
      for (i = 0; i < 4; i = i + 1) begin
        nom_reg[i] <= `ICSM_NOM_RST;
      end
    end else if (wr) begin
      case (wb_adr_i)
        `ICSM_A_CTRL:   ctrl_reg   <= (ctrl_reg & ~bm) | (wb_dat_i & bm);
        `ICSM_A_LOSCFG: loscfg_reg <= (loscfg_reg & ~bm) | (wb_dat_i & bm);
        `ICSM_A_PRIO:   prio_reg   <= (prio_reg & ~bm) | (wb_dat_i & bm);
        `ICSM_A_WIN:    win_reg    <= (win_reg & ~bm) | (wb_dat_i & bm);
        `ICSM_A_LIM:    lim_reg    <= (lim_reg & ~bm) | (wb_dat_i & bm);
        `ICSM_A_MASK:   mask_reg   <= (mask_reg & ~bm) | (wb_dat_i & bm);
        `ICSM_A_NOM0:   nom_reg[0] <= (nom_reg[0] & ~bm[23:0]) | (wb_dat_i[23:0] & bm[23:0]);
        `ICSM_A_NOM1:   nom_reg[1] <= (nom_reg[1] & ~bm[23:0]) | (wb_dat_i[23:0] & bm[23:0]);
        `ICSM_A_NOM2:   nom_reg[2] <= (nom_reg[2] & ~bm[23:0]) | (wb_dat_i[23:0] & bm[23:0]);
        `ICSM_A_NOM3:   nom_reg[3] <= (nom_reg[3] & ~bm[23:0]) | (wb_dat_i[23:0] & bm[23:0]);
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (wb_adr_i)
      `ICSM_A_CTRL:   rdata = {19'h0_0000, ctrl_reg[12:0]};
      `ICSM_A_LOSCFG: rdata = {27'h000_0000, loscfg_reg[4:0]};
      `ICSM_A_PRIO:   rdata = {24'h00_0000, prio_reg[7:0]};
      `ICSM_A_WIN:    rdata = {16'h0000, win_reg[15:0]};
      `ICSM_A_LIM:    rdata = lim_reg;
      `ICSM_A_LIVE:   rdata = live;
      `ICSM_A_STICKY: rdata = sticky_reg;
      `ICSM_A_MASK:   rdata = mask_reg;
      `ICSM_A_NOM0:   rdata = {8'h00, nom_reg[0]};
      `ICSM_A_NOM1:   rdata = {8'h00, nom_reg[1]};
      `ICSM_A_NOM2:   rdata = {8'h00, nom_reg[2]};
      `ICSM_A_NOM3:   rdata = {8'h00, nom_reg[3]};
      default:        rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= rdata;
      end
    end
  end

endmodule

// File: tb/icsm_top_props.sv
`timescale 1ns/10ps
module icsm_top_props (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Register bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  // Loop status
  input wire logic [1:0] active_sel_o,
  input wire logic       ref_valid_o,
  input wire logic       holdover_o,
  input wire logic       freerun_o,
  input wire logic       lock_loss_flag_o,
  input wire logic       phase_absorb_o,
  input wire logic       status_interrupt_pin_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_state_one;
    $onehot({ref_valid_o, holdover_o, freerun_o});
  endproperty
  a_state_one: assert property (p_state_one) else $error("loop state not one-hot");
  property p_pull_lol;
    $changed(active_sel_o) |-> lock_loss_flag_o [*8];
  endproperty
  a_pull_lol: assert property (p_pull_lol) else $error("lock loss dropped in pull-in");
  property p_lock_valid;
    !lock_loss_flag_o |-> ref_valid_o;
  endproperty
  a_lock_valid: assert property (p_lock_valid) else $error("locked without input");
  property p_absorb;
    phase_absorb_o |-> ref_valid_o && lock_loss_flag_o ##1 !phase_absorb_o;
  endproperty
  a_absorb: assert property (p_absorb) else $error("absorb pulse out of place");
  property p_irq_fall;
    $fell(status_interrupt_pin_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell unwritten");
  property p_hold_entry;
    $rose(holdover_o) |-> $past(ref_valid_o);
  endproperty
  a_hold_entry: assert property (p_hold_entry) else $error("holdover from free-run");
  c_absorb: cover property ($rose(phase_absorb_o));
  c_hold: cover property ($rose(holdover_o));
  c_irq: cover property ($fell(status_interrupt_pin_o));
endmodule
bind icsm_top icsm_top_props icsm_top_props_inst (
  .clk_i                  (clk_i),
  .rst_i                  (rst_i),
  .wb_cyc_i               (wb_cyc_i),
  .wb_stb_i               (wb_stb_i),
  .wb_we_i                (wb_we_i),
  .wb_ack_o               (wb_ack_o),
  .active_sel_o           (active_sel_o),
  .ref_valid_o            (ref_valid_o),
  .holdover_o             (holdover_o),
  .freerun_o              (freerun_o),
  .lock_loss_flag_o       (lock_loss_flag_o),
  .phase_absorb_o         (phase_absorb_o),
  .status_interrupt_pin_o (status_interrupt_pin_o)
);

// File: tb/icsm_src_model.sv
`timescale 1ns/10ps
module icsm_src_model (
  // Bench controls
  input  wire logic [4:0] run_i,
  input  wire logic [4:0] fast_i,
  input  wire logic [1:0] sel_code_i,
  // Pins toward the block
  output wire logic [3:0] clk_in_o,
  output wire logic       ref_o,
  output wire logic [1:0] sel_pin_o
);
  // ****************************************
  // Shared oscillator, phase unrelated to the system clock
  // ****************************************
  logic quick_reg = 1'b0;
  logic slow_reg  = 1'b0;
  initial begin
    #13;
    forever #100 quick_reg = ~quick_reg;
  end
  always @(posedge quick_reg) begin
    slow_reg <= ~slow_reg;
  end
  // Common edges keep frequency counts exact; a stopped source stands low
  assign clk_in_o  = run_i[3:0] & ((fast_i[3:0] & {4{quick_reg}}) | (~fast_i[3:0] & {4{slow_reg}}));
  assign ref_o     = run_i[4] & slow_reg;
  assign sel_pin_o = sel_code_i;
endmodule

// File: tb/tb_icsm_top.sv
`timescale 1ns/10ps
module tb_icsm_top;
  localparam int LIMIT = 20000;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [4:0]  run      = 5'h1F;
  logic [4:0]  fast     = 5'h00;
  logic [1:0]  sel_code = 2'h0;
  logic [31:0] rd_data;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  clk_in;
  logic        ref_pin;
  logic [1:0]  sel_pin;
  logic [1:0]  active_sel_o;
  logic        ref_valid_o;
  logic        holdover_o;
  logic        freerun_o;
  logic        lock_loss_flag_o;
  logic        phase_absorb_o;
  logic        outputs_enable_o;
  logic        status_interrupt_pin_o;
  int          failures   = 0;
  int          tests_run  = 0;
  int          cycles     = 0;
  int          absorb_cnt = 0;
  int          base;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20, 8'h40};
  logic [31:0] rv [8] = '{32'h0000_1800, 32'h0000_001F, 32'h0000_00E4, 32'h0000_0103,
                          32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_1000, 32'h0000_0000};
  icsm_top #(
    .GATE_LOG      (6),
    .FAST_LOG      (3),
    .PULLIN_CYCLES (24'h00_0014)
  ) icsm_top_inst (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .wb_cyc_i               (wb_cyc_i),
    .wb_stb_i               (wb_stb_i),
    .wb_we_i                (wb_we_i),
    .wb_adr_i               (wb_adr_i),
    .wb_sel_i               (4'hF),
    .wb_dat_i               (wb_dat_i),
    .wb_dat_o               (wb_dat_o),
    .wb_ack_o               (wb_ack_o),
    .clock_input_zero_i     (clk_in[0]),
    .clock_input_one_i      (clk_in[1]),
    .clock_input_two_i      (clk_in[2]),
    .clock_input_three_i    (clk_in[3]),
    .reference_pin_i        (ref_pin),
    .sel_pin_i              (sel_pin),
    .active_sel_o           (active_sel_o),
    .ref_valid_o            (ref_valid_o),
    .holdover_o             (holdover_o),
    .freerun_o              (freerun_o),
    .lock_loss_flag_o       (lock_loss_flag_o),
    .phase_absorb_o         (phase_absorb_o),
    .outputs_enable_o       (outputs_enable_o),
    .status_interrupt_pin_o (status_interrupt_pin_o)
  );
  icsm_src_model icsm_src_model_inst (
    .run_i      (run),
    .fast_i     (fast),
    .sel_code_i (sel_code),
    .clk_in_o   (clk_in),
    .ref_o      (ref_pin),
    .sel_pin_o  (sel_pin)
  );
  // ****************************************
  // Clock, watchdog and counters
  // ****************************************
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (phase_absorb_o === 1'b1)
      absorb_cnt++;
    if (cycles == LIMIT) begin
      failures++;
      print_verdict();
    end
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic bus(input logic we_v, input logic [7:0] adr_v, input logic [31:0] wd_v);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we_v;
    wb_adr_i <= adr_v;
    wb_dat_i <= wd_v;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_data = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr_v, input logic [31:0] wd_v);
    bus(1'b1, adr_v, wd_v);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic check_reg(input logic [7:0] adr_v, input logic [31:0] exp_v,
                           input logic [31:0] msk_v);
    bus(1'b0, adr_v, 32'h0000_0000);
    tests_run++;
    if ((rd_data & msk_v) !== (exp_v & msk_v)) begin
      failures++;
      $display("Error reg %h expected %h seen %h", adr_v, exp_v & msk_v, rd_data & msk_v);
    end
  endtask
  task automatic cmp_pin(input string nm, input logic [1:0] exp_v, input logic [1:0] got_v);
    tests_run++;
    if (got_v !== exp_v) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp_v, got_v);
    end
  endtask
  task print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++)
      check_reg(ra[i], rv[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++)
      wr(8'h20 + 8'(4 * i), 32'h0000_0040);
    wr(8'h10, 32'h20FF_2020);
    idle(1500);
    check_reg(8'h14, 32'h0000_0000, 32'h0000_1F1F);
    for (int c = 3; c >= 0; c--) begin
      sel_code <= 2'(c);
      idle(10);
      cmp_pin("active_sel", 2'(c), active_sel_o);
      cmp_pin("lock_loss", 2'd1, {1'b0, lock_loss_flag_o});
      idle(40);
      cmp_pin("lock_loss", 2'd0, {1'b0, lock_loss_flag_o});
    end
    cmp_pin("absorb", 2'd0, 2'(absorb_cnt));
    wr(8'h00, 32'h0000_1805);
    idle(10);
    cmp_pin("active_sel", 2'd2, active_sel_o);
    idle(40);
    wr(8'h00, 32'h0000_1827);
    idle(10);
    cmp_pin("holdover", 2'd1, {1'b0, holdover_o});
    wr(8'h00, 32'h0000_1823);
    idle(10);
    cmp_pin("active_sel", 2'd1, active_sel_o);
    idle(40);
    wr(8'h1C, 32'h0000_0002);
    wr(8'h04, 32'h0000_0017);
    run <= 5'h11;
    idle(60);
    cmp_pin("holdover", 2'd1, {1'b0, holdover_o});
    cmp_pin("interrupt", 2'd1, {1'b0, status_interrupt_pin_o});
    check_reg(8'h14, 32'h0000_0002, 32'h0000_001F);
    run <= 5'h1F;
    idle(40);
    check_reg(8'h14, 32'h0000_0000, 32'h0000_001F);
    check_reg(8'h18, 32'h0000_0002, 32'h0000_001F);
    wr(8'h18, 32'h0000_0002);
    idle(3);
    cmp_pin("interrupt", 2'd0, {1'b0, status_interrupt_pin_o});
    check_reg(8'h18, 32'h0000_0000, 32'h0000_001F);
    wr(8'h04, 32'h0000_001F);
    wr(8'h00, 32'h0000_0058);
    idle(1500);
    cmp_pin("active_sel", 2'd0, active_sel_o);
    base = absorb_cnt;
    run <= 5'h1E;
    idle(60);
    cmp_pin("active_sel", 2'd1, active_sel_o);
    run <= 5'h1F;
    idle(1500);
    cmp_pin("active_sel", 2'd0, active_sel_o);
    cmp_pin("absorb", 2'd2, 2'(absorb_cnt - base));
    wr(8'h00, 32'h0000_1848);
    run <= 5'h1E;
    idle(60);
    run <= 5'h1F;
    idle(1500);
    cmp_pin("active_sel", 2'd1, active_sel_o);
    run <= 5'h10;
    idle(300);
    cmp_pin("holdover", 2'd1, {1'b0, holdover_o});
    wr(8'h08, 32'h0000_003F);
    wr(8'h00, 32'h0000_1838);
    run <= 5'h18;
    idle(1500);
    cmp_pin("holdover", 2'd1, {1'b0, holdover_o});
    wr(8'h00, 32'h0000_1818);
    idle(10);
    cmp_pin("active_sel", 2'd3, active_sel_o);
    run <= 5'h08;
    idle(100);
    cmp_pin("outputs_enable", 2'd0, {1'b0, outputs_enable_o});
    wr(8'h00, 32'h0000_1898);
    idle(3);
    cmp_pin("outputs_enable", 2'd1, {1'b0, outputs_enable_o});
    run  <= 5'h1F;
    fast <= 5'h04;
    idle(1500);
    check_reg(8'h14, 32'h0000_0400, 32'h0000_0F00);
    wr(8'h00, 32'h0000_0098);
    idle(1500);
    check_reg(8'h14, 32'h0000_0000, 32'h0000_0F00);
    print_verdict();
  end
endmodule
